// ---- core/supervisor_pkg.sv ----
// Purpose: Shared constants and types of the supply supervisor gating logic.
// Assumes: A 50 MHz system clock; timeout periods are counted in base ticks.
// Notes: A base tick is 1 ms in the fixed modes, one oscillator edge otherwise.
package supervisor_pkg;

  // System clock.
  localparam int CLK_MHZ = 50;

  // Fixed-mode periods in milliseconds.
  localparam int WD_LONG_MS = 1600;
  localparam int WD_SHORT_MS = 100;
  localparam int RST_MS = 200;

  // External-oscillator periods in oscillator clocks.
  localparam int EXT_WD_CLOCKS = 1024;
  localparam int EXT_WD_AFTER_CLOCKS = 4096;
  localparam int EXT_RST_CLOCKS = 2048;

  // Least kick pulse, power-down grace and the 1 ms base tick.
  localparam int KICK_MIN_NS = 100;
  localparam int KICK_MIN_CYC = (KICK_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int CE_GRACE_NS = 12000;
  localparam int CE_GRACE_CYC = (CE_GRACE_NS * CLK_MHZ) / 1000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;

  // Reset values of the registered outputs.
  localparam logic RST_RESET_N = 1'b0;
  localparam logic RST_WD_EXPIRED_N = 1'b1;
  localparam logic RST_CE_OUT_N = 1'b1;

  localparam int CNT_W = 16;
  typedef logic [CNT_W-1:0] cnt_t;

  typedef enum logic [1:0] {tm_fixed_long, tm_fixed_short, tm_external} timing_mode_e;
  typedef enum logic [1:0] {gate_open, gate_grace, gate_closed} gate_state_e;

endpackage

// ---- core/supervisor_if.sv ----
// Purpose: Carriers between the supervisor top and its helper modules.
// Assumes: All signals but the raw inputs of cond_if and the external-mode tick of timer_if, taken from the raw oscillator pin, are in the mclk domain.
// Notes: One timer_if per timeout counter.
`timescale 1ns/100ps
interface cond_if;
  logic thr_raw;
  logic bat_raw;
  logic pf_raw;
  logic kick_raw;
  logic open_raw;
  logic thr;
  logic bat;
  logic pf;
  logic open;
  logic kick_edge;
  modport top (output thr_raw, bat_raw, pf_raw, kick_raw, open_raw,
               input thr, bat, pf, open, kick_edge);
  modport cond (input thr_raw, bat_raw, pf_raw, kick_raw, open_raw,
                output thr, bat, pf, open, kick_edge);
endinterface

interface timer_if;
  logic restart;
  logic tick;
  supervisor_pkg::cnt_t limit;
  logic expired;
  modport ctrl (output restart, tick, limit, input expired);
  modport timer (input restart, tick, limit, output expired);
endinterface

// ---- core/input_conditioner.sv ----
// Purpose: Synchronises comparator results and filters the watchdog kick.
// Assumes: Raw inputs may change at any time relative to mclk.
// Notes: A kick level must hold for the least pulse time before it counts.
`timescale 1ns/100ps
module input_conditioner
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Raw and conditioned signals.
  cond_if.cond c
);

  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic kick_level_r;
  logic [7:0] kick_cnt_r;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_r <= 5'h00;
      sync_r <= 5'h00;
    end
    else
    begin
      meta_r <= {c.open_raw, c.kick_raw, c.pf_raw, c.bat_raw, c.thr_raw};
      sync_r <= meta_r;
    end
  end

  assign c.thr = sync_r[0];
  assign c.bat = sync_r[1];
  assign c.pf = sync_r[2];
  assign c.open = sync_r[4];

  // A new kick level is accepted only after it has stood long enough.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      kick_level_r <= 1'b0;
      kick_cnt_r <= 8'h00;
      c.kick_edge <= 1'b0;
    end
    else
    begin
      c.kick_edge <= 1'b0;
      if (sync_r[3] == kick_level_r)
        kick_cnt_r <= 8'h00;
      else if (kick_cnt_r == 8'(supervisor_pkg::KICK_MIN_CYC - 1))
      begin
        kick_level_r <= sync_r[3];
        kick_cnt_r <= 8'h00;
        c.kick_edge <= 1'b1;
      end
      else
        kick_cnt_r <= kick_cnt_r + 8'h01;
    end
  end

endmodule

// ---- core/timeout_counter.sv ----
// Purpose: Counts base ticks up to a limit and flags the timeout.
// Assumes: Limit is stable while counting.
// Notes: The count saturates at the limit until restarted.
`timescale 1ns/100ps
module timeout_counter
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Control.
  timer_if.timer t
);

  supervisor_pkg::cnt_t cnt_r;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      cnt_r <= '0;
    else if (t.restart)
      cnt_r <= '0;
    else if (t.tick && (cnt_r < t.limit))
      cnt_r <= cnt_r + supervisor_pkg::cnt_t'(1);
  end

  assign t.expired = (cnt_r >= t.limit);

endmodule

// ---- core/supply_supervisor_gating_logic.sv ----
// Purpose: Reset, watchdog, chip-enable gating and backup control of a supply supervisor.
// Assumes: Comparator results arrive as digital levels; straps read high when floating.
// Notes: Analog switching is reduced to flags; the block is cleared when rstn falls.
`timescale 1ns/100ps
module supply_supervisor_gating_logic
#(
  parameter int TICK_CYCLES = supervisor_pkg::TICK_CYC
)
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Comparator results.
  input wire logic supply_below_threshold,
  input wire logic supply_below_battery,
  input wire logic power_fail_sense_in,
  // Timing straps.
  input wire logic timing_select_strap,
  input wire logic timing_oscillator_input,
  // Watchdog.
  input wire logic watchdog_kick_in,
  input wire logic watchdog_kick_open,
  output logic watchdog_expired_n,
  // Chip-enable gate.
  input wire logic chip_enable_in_n,
  output logic chip_enable_in_accept,
  output logic chip_enable_out_n,
  // Reset outputs; the active-high one is open drain.
  output logic reset_n,
  output logic reset_hi_o,
  output logic reset_hi_oe_n,
  // Status flags.
  output logic supply_low_flag,
  output logic power_fail_flag_n,
  output logic battery_on,
  output logic switched_supply_from_cell
);

  cond_if cif ();
  timer_if rst_t ();
  timer_if wd_t ();

  supervisor_pkg::timing_mode_e mode_r;
  supervisor_pkg::gate_state_e gate_r;
  supervisor_pkg::gate_state_e gate_nxt;
  logic [31:0] div_r;
  logic ms_tick_r;
  logic osc_prev_r;
  logic tick;
  logic reset_active_r;
  logic after_reset_r;
  logic backup_r;
  logic wd_enable;
  logic wd_fire;
  logic [15:0] grace_r;
  logic [15:0] grace_nxt;

  // Picks the timing mode from the two strap levels.
  function automatic supervisor_pkg::timing_mode_e decode_mode(input logic sel,
                                                               input logic osc);
    supervisor_pkg::timing_mode_e m;
    if (!sel)
      m = supervisor_pkg::tm_external;
    else if (!osc)
      m = supervisor_pkg::tm_fixed_short;
    else
      m = supervisor_pkg::tm_fixed_long;
    return m;
  endfunction

  // Watchdog limit in base ticks.
  function automatic supervisor_pkg::cnt_t wd_limit(input supervisor_pkg::timing_mode_e m,
                                                    input logic after);
    supervisor_pkg::cnt_t l;
    case (m)
      supervisor_pkg::tm_external:
        l = after ? supervisor_pkg::cnt_t'(supervisor_pkg::EXT_WD_AFTER_CLOCKS)
                  : supervisor_pkg::cnt_t'(supervisor_pkg::EXT_WD_CLOCKS);
      supervisor_pkg::tm_fixed_short:
        l = after ? supervisor_pkg::cnt_t'(supervisor_pkg::WD_LONG_MS)
                  : supervisor_pkg::cnt_t'(supervisor_pkg::WD_SHORT_MS);
      default:
        l = supervisor_pkg::cnt_t'(supervisor_pkg::WD_LONG_MS);
    endcase
    return l;
  endfunction

  // Reset timeout in base ticks.
  function automatic supervisor_pkg::cnt_t rst_limit(input supervisor_pkg::timing_mode_e m);
    supervisor_pkg::cnt_t l;
    if (m == supervisor_pkg::tm_external)
      l = supervisor_pkg::cnt_t'(supervisor_pkg::EXT_RST_CLOCKS);
    else
      l = supervisor_pkg::cnt_t'(supervisor_pkg::RST_MS);
    return l;
  endfunction

  // Comparator and kick conditioning.
  assign cif.thr_raw = supply_below_threshold;
  assign cif.bat_raw = supply_below_battery;
  assign cif.pf_raw = power_fail_sense_in;
  assign cif.kick_raw = watchdog_kick_in;
  assign cif.open_raw = watchdog_kick_open;

  input_conditioner u_cond
  (
    .mclk(mclk),
    .rstn(rstn),
    .c(cif)
  );

  // Backup mode needs both conditions; battery-on alone is not enough.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      backup_r <= 1'b0;
    else
      backup_r <= cif.thr && cif.bat;
  end

  // Straps are frozen while in backup, as they float there.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      mode_r <= supervisor_pkg::tm_fixed_long;
    else if (!backup_r)
      mode_r <= decode_mode(timing_select_strap, timing_oscillator_input);
  end

  // Base tick: a 1 ms divider or a rising edge of the oscillator pin.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_r <= 32'h0000_0000;
      ms_tick_r <= 1'b0;
    end
    else if (div_r == 32'(TICK_CYCLES - 1))
    begin
      div_r <= 32'h0000_0000;
      ms_tick_r <= 1'b1;
    end
    else
    begin
      div_r <= div_r + 32'h0000_0001;
      ms_tick_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      osc_prev_r <= 1'b0;
    else
      osc_prev_r <= timing_oscillator_input;
  end

  assign tick = (mode_r == supervisor_pkg::tm_external)
                ? (timing_oscillator_input && !osc_prev_r && !backup_r)
                : ms_tick_r;

  // Reset timer runs only while reset is held and the supply is good.
  assign rst_t.restart = cif.thr || wd_fire;
  assign rst_t.tick = tick && reset_active_r;
  assign rst_t.limit = rst_limit(mode_r);

  timeout_counter u_rst_timer
  (
    .mclk(mclk),
    .rstn(rstn),
    .t(rst_t)
  );

  // The watchdog sleeps while the supply is low, the kick pin floats or reset is held.
  assign wd_enable = !cif.thr && !cif.open && !backup_r && !reset_active_r;
  assign wd_t.restart = !wd_enable || cif.kick_edge;
  assign wd_t.tick = tick;
  assign wd_t.limit = wd_limit(mode_r, after_reset_r);
  assign wd_fire = wd_enable && wd_t.expired;

  timeout_counter u_wd_timer
  (
    .mclk(mclk),
    .rstn(rstn),
    .t(wd_t)
  );

  // Reset is held from the low supply until the timeout after recovery.
  // The power-fail result deliberately has no path into this logic.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      reset_active_r <= 1'b1;
    else if (cif.thr || wd_fire)
      reset_active_r <= 1'b1;
    else if (reset_active_r && rst_t.expired)
      reset_active_r <= 1'b0;
  end

  // The first watchdog period after a reset uses the long limit.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      after_reset_r <= 1'b1;
    else if (reset_active_r)
      after_reset_r <= 1'b1;
    else if (cif.kick_edge || wd_fire)
      after_reset_r <= 1'b0;
  end

  // Expired flag stays low until a kick, a low supply, a floating kick pin or backup; a fire in a kick's cycle wins, matching reset.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      watchdog_expired_n <= supervisor_pkg::RST_WD_EXPIRED_N;
    else if (wd_fire)
      watchdog_expired_n <= 1'b0;
    else if (cif.kick_edge || cif.thr || cif.open || backup_r)
      watchdog_expired_n <= 1'b1;
  end

  // Chip-enable gate sequencing.
  always_comb
  begin
    gate_nxt = gate_r;
    grace_nxt = grace_r;
    case (gate_r)
      supervisor_pkg::gate_open:
      begin
        grace_nxt = 16'h0000;
        if (reset_active_r)
          gate_nxt = chip_enable_in_n ? supervisor_pkg::gate_closed
                                      : supervisor_pkg::gate_grace;
      end
      supervisor_pkg::gate_grace:
      begin
        grace_nxt = grace_r + 16'h0001;
        if (chip_enable_in_n || (grace_r == 16'(supervisor_pkg::CE_GRACE_CYC - 1)))
          gate_nxt = supervisor_pkg::gate_closed;
      end
      supervisor_pkg::gate_closed:
      begin
        grace_nxt = 16'h0000;
        if (!reset_active_r)
          gate_nxt = supervisor_pkg::gate_open;
      end
      default:
      begin
        grace_nxt = 16'h0000;
        gate_nxt = supervisor_pkg::gate_closed;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      gate_r <= supervisor_pkg::gate_closed;
      grace_r <= 16'h0000;
    end
    else
    begin
      gate_r <= gate_nxt;
      grace_r <= grace_nxt;
    end
  end

  // The output lags the input by one clock; the gate itself is not combinational.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      chip_enable_out_n <= supervisor_pkg::RST_CE_OUT_N;
      chip_enable_in_accept <= 1'b0;
    end
    else if (gate_nxt == supervisor_pkg::gate_closed || backup_r)
    begin
      chip_enable_out_n <= 1'b1;
      chip_enable_in_accept <= 1'b0;
    end
    else
    begin
      chip_enable_out_n <= chip_enable_in_n;
      chip_enable_in_accept <= 1'b1;
    end
  end

  // Reset outputs; the open-drain one only sinks while reset is off.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      reset_n <= supervisor_pkg::RST_RESET_N;
      reset_hi_o <= 1'b0;
      reset_hi_oe_n <= 1'b1;
    end
    else
    begin
      reset_n <= !reset_active_r && !backup_r;
      reset_hi_o <= 1'b0;
      reset_hi_oe_n <= reset_active_r || backup_r;
    end
  end

  // Status flags.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      supply_low_flag <= 1'b0;
      power_fail_flag_n <= 1'b0;
      battery_on <= 1'b0;
      switched_supply_from_cell <= 1'b0;
    end
    else
    begin
      supply_low_flag <= !cif.thr && !backup_r;
      power_fail_flag_n <= cif.pf && !backup_r;
      battery_on <= cif.bat || backup_r;
      switched_supply_from_cell <= backup_r;
    end
  end

endmodule

// ---- dv/supervisor_asserts.sv ----
// Purpose: Port-level checks of the supply supervisor gating logic.
// Assumes: One clock domain; TICK_CYCLES matches the bound instance.
// Notes: Comparator checks wait out the synchronisers before comparing.
`timescale 1ns/100ps
module supervisor_asserts
#(
  parameter int TICK_CYCLES = 50
)
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Inputs watched.
  input wire logic supply_below_threshold,
  input wire logic supply_below_battery,
  input wire logic power_fail_sense_in,
  input wire logic chip_enable_in_n,
  // Outputs watched.
  input wire logic watchdog_expired_n,
  input wire logic chip_enable_in_accept,
  input wire logic chip_enable_out_n,
  input wire logic reset_n,
  input wire logic reset_hi_oe_n,
  input wire logic supply_low_flag,
  input wire logic power_fail_flag_n,
  input wire logic battery_on,
  input wire logic switched_supply_from_cell
);
  localparam int HOLD_MIN = (supervisor_pkg::RST_MS - 1) * TICK_CYCLES;
  localparam int CE_LIMIT = supervisor_pkg::CE_GRACE_CYC + 1;
  int grace_cnt_r, good_cnt_r;
  default clocking dck @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
      grace_cnt_r <= 0;
    else if (!reset_n && chip_enable_in_accept)
      grace_cnt_r <= grace_cnt_r + 1;
    else
      grace_cnt_r <= 0;
  // Saturates so that a long good-supply stretch cannot wrap.
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
      good_cnt_r <= 0;
    else if (supply_below_threshold)
      good_cnt_r <= 0;
    else if (good_cnt_r < 1000000)
      good_cnt_r <= good_cnt_r + 1;
  gate_pass_a:
    assert property (chip_enable_in_accept && $past(chip_enable_in_accept)
      |-> chip_enable_out_n == $past(chip_enable_in_n))
    else $error("gated chip-enable does not follow its input");
  gate_high_a:
    assert property (!chip_enable_in_accept |-> chip_enable_out_n)
    else $error("closed gate leaves chip-enable output low");
  grace_limit_a:
    assert property (grace_cnt_r <= CE_LIMIT)
    else $error("gate stays open too long after reset");
  supply_low_a:
    assert property ($stable(supply_below_threshold)[*5]
      |-> supply_low_flag == !supply_below_threshold)
    else $error("low-supply flag wrong");
  pf_flag_a:
    assert property (($stable(power_fail_sense_in) && $stable(switched_supply_from_cell))[*5]
      |-> power_fail_flag_n == (power_fail_sense_in && !switched_supply_from_cell))
    else $error("power-fail flag wrong");
  batt_on_a:
    assert property ($stable(supply_below_battery)[*5] |-> battery_on == supply_below_battery)
    else $error("battery-on flag wrong");
  backup_entry_a:
    assert property ($stable({supply_below_threshold, supply_below_battery})[*7]
      |-> switched_supply_from_cell == (supply_below_threshold && supply_below_battery))
    else $error("backup mode entered or left wrongly");
  backup_state_a:
    assert property (switched_supply_from_cell && $past(switched_supply_from_cell)
      |-> !reset_n && reset_hi_oe_n && watchdog_expired_n && chip_enable_out_n
          && !chip_enable_in_accept)
    else $error("backup output states wrong");
  reset_pair_a:
    assert property (reset_hi_oe_n != reset_n)
    else $error("reset outputs disagree");
  reset_hold_a:
    assert property ($rose(reset_n) |-> good_cnt_r >= HOLD_MIN)
    else $error("reset released before its timeout");
  expiry_reset_a:
    assert property ($fell(watchdog_expired_n) |-> ##[0:2] !reset_n)
    else $error("watchdog expiry did not assert reset");
endmodule
bind supply_supervisor_gating_logic supervisor_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk
  (.mclk, .rstn, .supply_below_threshold, .supply_below_battery, .power_fail_sense_in,
   .chip_enable_in_n, .watchdog_expired_n, .chip_enable_in_accept, .chip_enable_out_n,
   .reset_n, .reset_hi_oe_n, .supply_low_flag, .power_fail_flag_n, .battery_on,
   .switched_supply_from_cell);

// ---- dv/cpu_side_model.sv ----
// Purpose: Processor-side model driving chip-enable, kick and oscillator pins.
// Assumes: Bench commands change on the falling edge of mclk.
// Notes: Kick and oscillator change on the rising edge, as a clocked processor would.
`timescale 1ns/100ps
module cpu_side_model
(
  // Clock.
  input wire logic mclk,
  // Bench commands.
  input wire logic ce_req,
  input wire logic kick_req,
  input wire logic osc_run,
  input wire logic osc_idle,
  // Supervisor pins.
  output logic chip_enable_in_n,
  output logic watchdog_kick_in,
  output logic timing_oscillator_input
);
  logic kick_r = 1'b0;
  logic [1:0] div_r = 2'h0;
  assign chip_enable_in_n = ~ce_req;
  assign watchdog_kick_in = kick_r;
  assign timing_oscillator_input = osc_run ? div_r[1] : osc_idle;
  // A request held two cycles toggles twice, which is how a too-short pulse is made.
  always @(posedge mclk)
    if (kick_req)
      kick_r <= ~kick_r;
  always @(posedge mclk)
    div_r <= div_r + 2'h1;
endmodule

// ---- dv/supply_supervisor_gating_logic_bench.sv ----
// Purpose: Directed bench of the supply supervisor gating logic.
// Assumes: A 10-cycle base tick scales every fixed-mode period alike.
// Notes: Inputs change on the falling edge; every wait is bounded.
`timescale 1ns/100ps
module supply_supervisor_gating_logic_bench;
  localparam int TK = 10;
  logic mclk, rstn, supply_below_threshold, supply_below_battery, power_fail_sense_in;
  logic timing_select_strap, timing_oscillator_input, watchdog_kick_in, watchdog_kick_open;
  logic chip_enable_in_n, ce_req, kick_req, osc_run, osc_idle;
  logic watchdog_expired_n, chip_enable_in_accept, chip_enable_out_n, reset_n;
  logic reset_hi_oe_n, supply_low_flag, power_fail_flag_n, battery_on, switched_supply_from_cell;
  logic reset_hi_o;
  logic [2:0] obs;
  logic [8:0] outs;
  int num_errors, total_checks, n;
  assign obs = {chip_enable_in_accept, watchdog_expired_n, reset_n};
  assign outs = {switched_supply_from_cell, battery_on, power_fail_flag_n, supply_low_flag,
    reset_n, reset_hi_oe_n, watchdog_expired_n, chip_enable_out_n, chip_enable_in_accept};
  supply_supervisor_gating_logic #(.TICK_CYCLES(TK)) u_dut
    (.mclk, .rstn, .supply_below_threshold, .supply_below_battery, .power_fail_sense_in,
     .timing_select_strap, .timing_oscillator_input, .watchdog_kick_in, .watchdog_kick_open,
     .watchdog_expired_n, .chip_enable_in_n, .chip_enable_in_accept, .chip_enable_out_n,
     .reset_n, .reset_hi_o, .reset_hi_oe_n, .supply_low_flag, .power_fail_flag_n,
     .battery_on, .switched_supply_from_cell);
  cpu_side_model u_cpu
    (.mclk, .ce_req, .kick_req, .osc_run, .osc_idle, .chip_enable_in_n, .watchdog_kick_in,
     .timing_oscillator_input);
  task automatic chk(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_vec(input string what, input logic [8:0] exp);
    total_checks++;
    if (outs !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, outs);
    end
  endtask
  task automatic chk_rng(input string what, input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic run(input int c);
    repeat (c) @(negedge mclk);
  endtask
  // A wait that runs out is a mismatch and ends the run.
  task automatic wait_bit(input string what, input int b, input logic lvl, input int lim,
                          output int cnt);
    cnt = 0;
    while (obs[b] !== lvl)
    begin
      if (cnt == lim)
      begin
        chk(what, lvl, obs[b]);
        report_and_stop();
      end
      @(negedge mclk);
      cnt++;
    end
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial
  begin
    num_errors = 0;
    total_checks = 0;
    {rstn, supply_below_threshold, supply_below_battery, ce_req, kick_req, osc_run} = 6'h00;
    {power_fail_sense_in, timing_select_strap, watchdog_kick_open, osc_idle} = 4'hf;
    run(4);
    rstn = 1'b1;
    run(1000);
    chk("accept_in_reset", 1'b0, chip_enable_in_accept);
    wait_bit("reset_release", 0, 1'b1, 1200, n);
    chk_rng("reset_time", 1000 + n, 199 * TK, 201 * TK + 10);
    chk_vec("normal_outs", 9'h077);
    chk("reset_hi_sink", 1'b0, reset_hi_o);
    ce_req = 1'b1;
    run(1);
    chk("ce_pass_low", 1'b0, chip_enable_out_n);
    ce_req = 1'b0;
    run(1);
    chk("ce_pass_high", 1'b1, chip_enable_out_n);
    power_fail_sense_in = 1'b0;
    run(5);
    chk("pf_low", 1'b0, power_fail_flag_n);
    chk("pf_no_side", 1'b1, reset_n & chip_enable_in_accept);
    power_fail_sense_in = 1'b1;
    run(5);
    chk("pf_high", 1'b1, power_fail_flag_n);
    // An access in progress when the supply drops keeps the gate open for the grace time.
    ce_req = 1'b1;
    supply_below_threshold = 1'b1;
    wait_bit("reset_fall", 0, 1'b0, 10, n);
    run(300);
    chk("grace_open", 1'b1, chip_enable_in_accept);
    wait_bit("grace_close", 2, 1'b0, 400, n);
    chk_rng("grace_len", 300 + n, 590, 602);
    chk("ce_out_closed", 1'b1, chip_enable_out_n);
    ce_req = 1'b0;
    supply_below_threshold = 1'b0;
    wait_bit("reset_back", 0, 1'b1, 2100, n);
    supply_below_threshold = 1'b1;
    wait_bit("quick_close", 2, 1'b0, 8, n);
    chk_rng("quick_close_time", n, 2, 6);
    run(6);
    chk("no_backup", 1'b0, switched_supply_from_cell | battery_on);
    supply_below_battery = 1'b1;
    run(8);
    chk_vec("backup_outs", 9'h18e);
    supply_below_threshold = 1'b0;
    run(8);
    chk("leave_backup", 1'b0, switched_supply_from_cell);
    chk("batt_still_on", 1'b1, battery_on);
    supply_below_battery = 1'b0;
    wait_bit("reset_after_backup", 0, 1'b1, 2100, n);
    watchdog_kick_open = 1'b0;
    wait_bit("wd_long_fire", 1, 1'b0, 16200, n);
    chk_rng("wd_long", n, 1599 * TK, 1601 * TK + 10);
    run(3);
    chk("wd_reset", 1'b0, reset_n);
    wait_bit("wd_reset_end", 0, 1'b1, 2100, n);
    chk("expired_held", 1'b0, watchdog_expired_n);
    osc_idle = 1'b0;
    kick_req = 1'b1;
    run(1);
    kick_req = 1'b0;
    run(10);
    chk("expired_cleared", 1'b1, watchdog_expired_n);
    run(390);
    // A one-cycle kick pulse must not restart the watchdog.
    kick_req = 1'b1;
    run(2);
    kick_req = 1'b0;
    wait_bit("wd_short_fire", 1, 1'b0, 800, n);
    chk_rng("wd_short", 403 + n, 99 * TK, 101 * TK + 15);
    // With no kick, the first period after this watchdog reset is the long one.
    run(3);
    wait_bit("short_reset_end", 0, 1'b1, 2100, n);
    wait_bit("wd_after_reset_fire", 0, 1'b0, 16200, n);
    chk_rng("wd_after_reset", n, 1599 * TK, 1601 * TK + 10);
    watchdog_kick_open = 1'b1;
    timing_select_strap = 1'b0;
    osc_run = 1'b1;
    supply_below_threshold = 1'b1;
    run(6);
    supply_below_threshold = 1'b0;
    wait_bit("ext_reset_end", 0, 1'b1, 8400, n);
    chk_rng("ext_reset", n, 2047 * 4, 2049 * 4 + 10);
    report_and_stop();
  end
endmodule
